// >>> rtl/i2sf_top.sv
// Audio FIFO setup block: APB registers, transmit FIFO with underrun fill, and serial transmitter.
//
// Contract
// - With zero fill cleared, an empty transmit FIFO makes the transmitter repeat the last sample sent.
// - With zero fill set, an empty transmit FIFO makes the transmitter send zero.
// - After an underrun the fill value keeps going out until pause, error clear, new data and unpause.
// - The wide packing bit selects 24-bit halves or a 32-bit then 16-bit split for 48-bit entries.
// - The size field reads 0x2 for sample lengths up to 16 bits or from 25 to 32 bits.
// - The size field reads 0x3 for sample lengths from 17 to 24 bits.
`timescale 1ns/1ps

module i2sf_top (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial audio link, clock and word select come from the partner
  input wire logic link_sck,
  input wire logic link_ws,
  output logic link_sd
);

  // APB-domain state: control fields, FIFO storage and the frame handed to the link.
  typedef struct packed {
    i2sf_pkg::i2sf_ctrl_t ctrl;
    logic underrun;
    logic fill_lock;
    logic [i2sf_pkg::FIFO_DEPTH-1:0][63:0] mem;
    logic [2:0] wptr;
    logic [2:0] rptr;
    logic [3:0] count;
    logic [31:0] half;
    logic half_vld;
    i2sf_pkg::i2sf_frame_t hold;
    logic [2:0] req_sync;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } i2sf_apb_state_t;

  // Link-domain state: word select history, the frame being sent and the shifter.
  typedef struct packed {
    logic ws_d;
    logic req_tgl;
    i2sf_pkg::i2sf_frame_t cur;
    logic [31:0] shift;
    logic sd;
  } i2sf_link_state_t;

  i2sf_apb_state_t s_r;
  i2sf_apb_state_t s_nxt;
  i2sf_link_state_t l_r;
  i2sf_link_state_t l_nxt;
  logic [1:0] link_rst_sync_r;
  logic link_rst_n;

  // Size code for a sample length; the read mux and the packing logic share it.
  function automatic logic [1:0] fifo_size(input logic [5:0] len);
    if (len >= i2sf_pkg::LEN_WIDE_MIN && len <= i2sf_pkg::LEN_WIDE_MAX) begin
      fifo_size = i2sf_pkg::SIZE_ENTRY48;
    end else begin
      fifo_size = i2sf_pkg::SIZE_ENTRY32;
    end
  endfunction

  // Places the sample MSB at bit 31 so the shifter can send MSB first for any length.
  function automatic logic [31:0] msb_align(input logic [31:0] v, input logic [5:0] len);
    msb_align = v << (i2sf_pkg::LEN_FULL - len);
  endfunction

  logic [5:0] cur_len;
  logic wide_len;
  logic acc_setup;
  logic acc_wr;
  logic push;
  logic pop;
  logic req_edge;
  logic [31:0] push_left;
  logic [31:0] push_right;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [31:0] left_al;
  logic [31:0] right_al;

  assign cur_len = {1'b0, s_r.ctrl.sample_len_m1} + 6'h01;
  assign wide_len = (fifo_size(cur_len) == i2sf_pkg::SIZE_ENTRY48);
  assign acc_setup = psel && !penable;
  // A write lands only in the cycle where the registered ready is high.
  assign acc_wr = psel && penable && s_r.pready && pwrite;
  assign req_edge = s_r.req_sync[2] ^ s_r.req_sync[1];
  assign left_al = msb_align(s_r.hold.left, s_r.hold.len);
  assign right_al = msb_align(l_r.cur.right, l_r.cur.len);

  // Read mux; the size field is computed here and has no storage a write could reach.
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      i2sf_pkg::ADDR_AUDIO_SETUP: begin
        rd_word = {25'h000_0000, s_r.ctrl.pause, s_r.ctrl.single_channel_pair_mode, s_r.ctrl.sample_len_m1};
      end
      i2sf_pkg::ADDR_FIFO_SETUP: begin
        // Bits 11:6 read as zero.
        rd_word = {26'h000_0000, fifo_size(cur_len), s_r.ctrl.wide_entry_packing,
                   s_r.ctrl.tx_underrun_zero_fill, s_r.ctrl.rx_en, s_r.ctrl.tx_en};
      end
      i2sf_pkg::ADDR_FIFO_STATUS: begin
        rd_word = {24'h00_0000, s_r.count, s_r.fill_lock, (s_r.count == i2sf_pkg::FIFO_FULL_COUNT),
                   (s_r.count == 4'h0), s_r.underrun};
      end
      i2sf_pkg::ADDR_FIFO_WRITE: begin
        rd_word = 32'h0000_0000;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Builds a stereo frame from FIFO writes according to length, single_channel_pair_mode and packing.
  always_comb begin
    push_left = 32'h0000_0000;
    push_right = 32'h0000_0000;
    push = 1'b0;
    if (acc_wr && paddr == i2sf_pkg::ADDR_FIFO_WRITE) begin
      if (cur_len <= i2sf_pkg::LEN_NARROW_MAX) begin
        push = 1'b1;
        push_left = {16'h0000, pwdata[15:0]};
        push_right = s_r.ctrl.single_channel_pair_mode ? {16'h0000, pwdata[15:0]} : {16'h0000, pwdata[31:16]};
      end else if (s_r.ctrl.single_channel_pair_mode) begin
        push = 1'b1;
        push_left = wide_len ? {8'h00, pwdata[23:0]} : pwdata;
        push_right = push_left;
      end else if (s_r.half_vld) begin
        push = 1'b1;
        if (wide_len && s_r.ctrl.wide_entry_packing) begin
          // Entry split as 32 low bits then 16 high bits of the 48-bit pair.
          push_left = {8'h00, s_r.half[23:0]};
          push_right = {8'h00, pwdata[15:0], s_r.half[31:24]};
        end else if (wide_len) begin
          // Entry taken as two 24-bit values.
          push_left = {8'h00, s_r.half[23:0]};
          push_right = {8'h00, pwdata[23:0]};
        end else begin
          push_left = s_r.half;
          push_right = pwdata;
        end
      end
    end
  end

  // Register writes, FIFO bookkeeping and frame requests, all on the APB clock.
  always_comb begin
    s_nxt = s_r;
    pop = 1'b0;
    s_nxt.req_sync = {s_r.req_sync[1:0], l_r.req_tgl};
    s_nxt.pready = acc_setup;
    s_nxt.pslverr = acc_setup && !rd_hit;
    s_nxt.prdata = acc_setup ? rd_word : 32'h0000_0000;

    if (acc_wr) begin
      case (paddr)
        i2sf_pkg::ADDR_AUDIO_SETUP: begin
          s_nxt.ctrl.sample_len_m1 = pwdata[4:0];
          s_nxt.ctrl.single_channel_pair_mode = pwdata[5];
          s_nxt.ctrl.pause = pwdata[6];
          // A half-built pair belongs to the old format, so it is dropped.
          s_nxt.half_vld = 1'b0;
        end
        i2sf_pkg::ADDR_FIFO_SETUP: begin
          s_nxt.ctrl.tx_en = pwdata[0];
          s_nxt.ctrl.rx_en = pwdata[1];
          s_nxt.ctrl.tx_underrun_zero_fill = pwdata[2];
          s_nxt.ctrl.wide_entry_packing = pwdata[3];
        end
        i2sf_pkg::ADDR_FIFO_STATUS: begin
          if (pwdata[0]) begin
            s_nxt.underrun = 1'b0;
          end
        end
        i2sf_pkg::ADDR_FIFO_WRITE: begin
          if (!push && cur_len > i2sf_pkg::LEN_NARROW_MAX && !s_r.ctrl.single_channel_pair_mode) begin
            s_nxt.half = pwdata;
            s_nxt.half_vld = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // Writes into a full FIFO are lost; software is expected to watch the full flag.
    if (push) begin
      s_nxt.half_vld = 1'b0;
      if (s_r.count != i2sf_pkg::FIFO_FULL_COUNT) begin
        s_nxt.mem[s_r.wptr] = {push_left, push_right};
        s_nxt.wptr = s_r.wptr + i2sf_pkg::PTR_ONE;
      end
    end

    // Release only after a pause with the error cleared; data then resumes on unpause.
    if (s_r.fill_lock && s_r.ctrl.pause && !s_r.underrun) begin
      s_nxt.fill_lock = 1'b0;
    end

    // Each request from the link loads the frame for the frame after the one now starting.
    if (req_edge) begin
      s_nxt.hold.len = cur_len;
      if (s_r.ctrl.tx_en && !s_r.ctrl.pause && !s_r.fill_lock && s_r.count != 4'h0) begin
        pop = 1'b1;
        s_nxt.hold.left = s_r.mem[s_r.rptr][63:32];
        s_nxt.hold.right = s_r.mem[s_r.rptr][31:0];
        s_nxt.rptr = s_r.rptr + i2sf_pkg::PTR_ONE;
      end else begin
        if (s_r.ctrl.tx_en && !s_r.ctrl.pause && !s_r.fill_lock) begin
          // Set after the clear above so an underrun in the clearing cycle is kept.
          s_nxt.underrun = 1'b1;
          s_nxt.fill_lock = 1'b1;
        end
        if (s_r.ctrl.tx_underrun_zero_fill) begin
          s_nxt.hold.left = 32'h0000_0000;
          s_nxt.hold.right = 32'h0000_0000;
        end
        // Otherwise the hold register keeps the last frame, which is sent again.
      end
    end

    // A pop and a push into a FIFO that is not full in one cycle leave the count where it is.
    if (push && s_r.count != i2sf_pkg::FIFO_FULL_COUNT && !pop) begin
      s_nxt.count = s_r.count + i2sf_pkg::FIFO_ONE;
    end else if (pop && !(push && s_r.count != i2sf_pkg::FIFO_FULL_COUNT)) begin
      s_nxt.count = s_r.count - i2sf_pkg::FIFO_ONE;
    end
  end

  // The reset branch names sample_len_m1 and hold.len, whose reset values are not zero, and also tx_en, which resets to zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.ctrl.sample_len_m1 <= i2sf_pkg::LEN_M1_RST;
      s_r.ctrl.tx_en <= i2sf_pkg::RST_OFF;
      s_r.hold.len <= i2sf_pkg::LEN_NARROW_MAX;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Link reset asserts at once and releases on the link clock.
  always_ff @(posedge link_sck or negedge presetn) begin
    if (!presetn) begin
      link_rst_sync_r <= 2'h0;
    end else begin
      link_rst_sync_r <= {link_rst_sync_r[0], 1'b1};
    end
  end

  assign link_rst_n = link_rst_sync_r[1];

  // The hold frame is read only at the start of a left slot; it last changed just after the
  // previous request, a whole frame earlier, so it is stable when sampled here.
  always_comb begin
    l_nxt = l_r;
    l_nxt.ws_d = link_ws;
    l_nxt.shift = {l_r.shift[30:0], 1'b0};
    l_nxt.sd = l_r.shift[31];
    if (link_ws != l_r.ws_d) begin
      if (!link_ws) begin
        l_nxt.cur = s_r.hold;
        l_nxt.req_tgl = !l_r.req_tgl;
        l_nxt.sd = left_al[31];
        l_nxt.shift = {left_al[30:0], 1'b0};
      end else begin
        l_nxt.sd = right_al[31];
        l_nxt.shift = {right_al[30:0], 1'b0};
      end
    end
  end

  // The synchronised reset lets the link state leave reset on a clean link clock edge.
  always_ff @(posedge link_sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  // Every output is a register bit, so no decode glitch reaches the pins.
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign link_sd = l_r.sd;

endmodule

// >>> rtl/i2sf_pkg.sv
// Package with register map, field constants and carrier types for the audio FIFO setup block.
package i2sf_pkg;

  // Register byte addresses.
  localparam logic [11:0] ADDR_AUDIO_SETUP = 12'hc00;
  localparam logic [11:0] ADDR_FIFO_SETUP = 12'he00;
  localparam logic [11:0] ADDR_FIFO_STATUS = 12'he04;
  localparam logic [11:0] ADDR_FIFO_WRITE = 12'he20;

  // FIFO size codes reported in the read-only size field.
  localparam logic [1:0] SIZE_ENTRY32 = 2'h2;
  localparam logic [1:0] SIZE_ENTRY48 = 2'h3;

  // Sample length limits in bits.
  localparam logic [5:0] LEN_FULL = 6'h20;
  localparam logic [5:0] LEN_NARROW_MAX = 6'h10;
  localparam logic [5:0] LEN_WIDE_MIN = 6'h11;
  localparam logic [5:0] LEN_WIDE_MAX = 6'h18;

  // Reset values of the writable fields.
  localparam logic [4:0] LEN_M1_RST = 5'h0f;
  localparam logic RST_OFF = 1'b0;

  // Transmit FIFO geometry.
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] FIFO_FULL_COUNT = 4'h8;
  localparam logic [3:0] FIFO_ONE = 4'h1;
  localparam logic [2:0] PTR_ONE = 3'h1;

  // One stereo frame as it travels to the serial link.
  typedef struct packed {
    logic [31:0] left;
    logic [31:0] right;
    logic [5:0] len;
  } i2sf_frame_t;

  // Software-visible control fields.
  typedef struct packed {
    logic tx_en;
    logic rx_en;
    logic tx_underrun_zero_fill;
    logic wide_entry_packing;
    logic [4:0] sample_len_m1;
    logic single_channel_pair_mode;
    logic pause;
  } i2sf_ctrl_t;

endpackage

// >>> testbench/i2sf_top_sva.sv
// Checker for the register side of the audio FIFO setup block.
`timescale 1ns/1ps
module i2sf_top_sva (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic [4:0] len_r;
  logic [1:0] size_exp;
  logic mapped;
  logic rd_setup;
  // The length is mirrored from completed writes, so the size check never trusts the design's own copy.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) len_r <= i2sf_pkg::LEN_M1_RST;
    else if (psel && penable && pready && pwrite && !pslverr && paddr == i2sf_pkg::ADDR_AUDIO_SETUP)
      len_r <= pwdata[4:0];
  end
  assign mapped = paddr inside {i2sf_pkg::ADDR_AUDIO_SETUP, i2sf_pkg::ADDR_FIFO_SETUP,
    i2sf_pkg::ADDR_FIFO_STATUS, i2sf_pkg::ADDR_FIFO_WRITE};
  assign rd_setup = pready && !pwrite && paddr == i2sf_pkg::ADDR_FIFO_SETUP;
  assign size_exp = (len_r >= 5'h10 && len_r <= 5'h17) ? i2sf_pkg::SIZE_ENTRY48 : i2sf_pkg::SIZE_ENTRY32;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    pready ##1 !pready;
  endsequence
  ready_after_setup_a: assert property (setup_s |=> answer_s) else $error("late or long pready");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  idle_data_zero_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
  unmapped_err_a: assert property (setup_s ##0 !mapped |=> pslverr) else $error("no error on unmapped");
  mapped_ok_a: assert property (setup_s ##0 mapped |=> !pslverr) else $error("error on mapped");
  size_field_a: assert property (rd_setup |-> prdata[5:4] == size_exp) else $error("size wrong");
  reserved_zero_a: assert property (rd_setup |-> prdata[31:6] == 26'h0) else $error("upper bits set");
  write_only_zero_a: assert property (pready && !pwrite && paddr == i2sf_pkg::ADDR_FIFO_WRITE |-> prdata == 32'h0)
    else $error("write port read back");
endmodule
bind i2sf_top i2sf_top_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// >>> testbench/i2sf_codec.sv
// Codec model: drives link clock and word select, captures each 32-bit slot.
`timescale 1ns/1ps
module i2sf_codec (
  // Link
  output logic sck,
  output logic ws,
  input wire logic sd,
  // Captured slots
  output logic [31:0] left,
  output logic [31:0] right,
  output int frames
);
  logic [31:0] sh;
  logic [4:0] fc;
  initial begin
    {sck, ws, fc, sh, left, right, frames} = '0;
    #13;
    forever #40 sck = ~sck;
  end
  // Word select moves on the falling edge so the device samples it settled.
  always @(negedge sck) begin
    fc <= fc + 5'h1;
    if (fc == 5'h1f) ws <= ~ws;
  end
  // One bit of delay: the slot is whole at the first rise after the next change.
  always @(posedge sck) begin
    sh <= {sh[30:0], sd};
    if (fc == 5'h0 && ws) left <= {sh[30:0], sd};
    if (fc == 5'h0 && !ws) right <= {sh[30:0], sd};
    if (fc == 5'h0 && ws) frames <= frames + 1;
  end
endmodule

// >>> testbench/i2sf_top_bench.sv
// Bench for the audio FIFO setup block: APB tasks, codec model and scenarios.
`timescale 1ns/1ps
module i2sf_top_bench;
  localparam logic [11:0] A_AUD = i2sf_pkg::ADDR_AUDIO_SETUP;
  localparam logic [11:0] A_CFG = i2sf_pkg::ADDR_FIFO_SETUP;
  localparam logic [11:0] A_STA = i2sf_pkg::ADDR_FIFO_STATUS;
  localparam logic [11:0] A_WR = i2sf_pkg::ADDR_FIFO_WRITE;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, c_left, c_right, rd;
  logic pready, pslverr, link_sck, link_ws, link_sd, err;
  int frames;
  int num_errors = 0;
  int samples_checked = 0;
  i2sf_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_sck(link_sck), .link_ws(link_ws), .link_sd(link_sd));
  i2sf_codec i_codec (.sck(link_sck), .ws(link_ws), .sd(link_sd), .left(c_left), .right(c_right),
    .frames(frames));
  initial begin
    forever #2 pclk = ~pclk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic step(inout int n);
    @(posedge pclk);
    n++;
    if (n > 20000) begin
      check("wait bound", 32'h0, 32'h1);
      test_done();
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do step(n); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wait_right(input logic [31:0] exp);
    int n = 0;
    while (c_right !== exp) step(n);
  endtask
  task automatic wait_frames(input int k);
    int n = 0;
    int f = frames + k;
    while (frames < f) step(n);
  endtask
  // Pause, clear the error, supply data, then resume: the only way out of the fill.
  task automatic load(input logic [4:0] m1, input logic [3:0] cfg, input logic [31:0] w0, input logic [31:0] w1);
    apb(1'b1, A_AUD, {25'h0, 1'b1, 1'b0, m1});
    apb(1'b1, A_STA, 32'h1);
    apb(1'b1, A_CFG, {28'h0, cfg});
    apb(1'b1, A_WR, w0);
    if (m1 > 5'h0f) apb(1'b1, A_WR, w1);
    apb(1'b1, A_AUD, {27'h0, m1});
  endtask
  task automatic test_size();
    logic [4:0] m1 [6] = '{5'h07, 5'h0f, 5'h10, 5'h17, 5'h18, 5'h1f};
    logic [1:0] sz [6] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h2};
    apb(1'b0, A_CFG, 32'h0);
    check("setup reset", rd, 32'h20);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, A_AUD, {27'h0, m1[i]});
      apb(1'b1, A_CFG, 32'h30);
      apb(1'b0, A_CFG, 32'h0);
      check("size field", {30'h0, rd[5:4]}, {30'h0, sz[i]});
    end
    apb(1'b0, 12'hffc, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    $display("test_size done");
  endtask
  task automatic test_repeat();
    load(5'h0f, 4'h1, 32'h12345678, 32'h0);
    wait_right(32'h12340000);
    wait_frames(3);
    check("repeat left", c_left, 32'h56780000);
    check("repeat right", c_right, 32'h12340000);
    apb(1'b0, A_STA, 32'h0);
    check("underrun flag", {31'h0, rd[0]}, 32'h1);
    load(5'h0f, 4'h1, 32'h43218765, 32'h0);
    wait_right(32'h43210000);
    check("resumed left", c_left, 32'h87650000);
    $display("test_repeat done");
  endtask
  task automatic test_zero();
    load(5'h0f, 4'h5, 32'h11112222, 32'h0);
    wait_right(32'h11110000);
    wait_frames(3);
    check("zero left", c_left, 32'h0);
    check("zero right", c_right, 32'h0);
    $display("test_zero done");
  endtask
  task automatic test_pack();
    logic [31:0] exp [2] = '{32'h00112200, 32'h1122aa00};
    for (int p = 0; p < 2; p++) begin
      load(5'h17, {p[0], 3'h5}, 32'haabbccdd, 32'h00001122);
      wait_right(exp[p]);
      check("packed right", c_right, exp[p]);
      check("packed left", c_left, 32'hbbccdd00);
    end
    $display("test_pack done");
  endtask
  // Single_channel_pair_mode at 32 bits: one write feeds both channels, and the repeat fill keeps both.
  task automatic test_single_channel_pair_mode();
    apb(1'b1, A_AUD, 32'h0000007f);
    apb(1'b1, A_STA, 32'h00000001);
    apb(1'b1, A_CFG, 32'h00000001);
    apb(1'b1, A_WR, 32'hcafe0123);
    apb(1'b1, A_AUD, 32'h0000003f);
    wait_right(32'hcafe0123);
    check("single_channel_pair_mode left", c_left, 32'hcafe0123);
    wait_frames(2);
    check("single_channel_pair_mode repeat left", c_left, 32'hcafe0123);
    check("single_channel_pair_mode repeat right", c_right, 32'hcafe0123);
    $display("test_single_channel_pair_mode done");
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    test_size();
    test_repeat();
    test_zero();
    test_pack();
    test_single_channel_pair_mode();
    test_done();
  end
endmodule
